// ==== logic/lpm_pkg.sv ====
// Shared constants and carrier types for the low-power mode controller.
// Assumes one 200 MHz clock domain and a synchronous active-high reset.
package lpm_pkg;

    // Power modes
    typedef enum logic [1:0] {
        LPM_ACTIVE = 2'b00,
        LPM_SLEEP  = 2'b01,
        LPM_POWER_DOWN_PIN   = 2'b10,
        LPM_RESET  = 2'b11
    } lpm_mode_t;

    // RAM/port 5 control register: address and RAM enable bit position
    localparam logic [15:0] LPM_RAMCTL_ADDR   = 16'h0014;
    localparam int          LPM_RAM_ACCESS_ENABLE_BIT_BIT      = 6;
    localparam logic        LPM_RAM_ACCESS_ENABLE_BIT_RESET    = 1'b1;
    localparam logic        LPM_STBYFLG_RESET = 1'b0;

    // Bus output levels used outside normal operation
    localparam logic [7:0]  LPM_BYTE_ONES     = 8'hff;
    localparam logic [7:0]  LPM_BYTE_ZERO     = 8'h00;
    localparam logic [4:0]  LPM_P2_ZERO       = 5'h00;
    localparam logic        LPM_RW_READ       = 1'b1;

    // Output enables are active low: 0 drives the pin
    localparam logic [7:0]  LPM_OE8_DRIVE     = 8'h00;
    localparam logic [7:0]  LPM_OE8_FLOAT     = 8'hff;
    localparam logic [4:0]  LPM_OE5_FLOAT     = 5'h1f;

    // Pin values and enables presented by the CPU/port core
    typedef struct packed {
        logic [4:0] p2_o;
        logic [4:0] p2_oe_n;
        logic [7:0] lo_o;
        logic [7:0] lo_oe_n;
        logic [7:0] hi_o;
        logic [7:0] hi_oe_n;
        logic [7:0] db_o;
        logic [7:0] db_oe_n;
        logic       rw_o;
        logic       as_o;
    } lpm_pins_t;

    // Pin state under block reset; enables float and rw_o reads as in the reset-mode override with e_clk high, but all other levels are zero
    localparam lpm_pins_t LPM_PINS_RESET = '{
        p2_o:    LPM_P2_ZERO,
        p2_oe_n: LPM_OE5_FLOAT,
        lo_o:    LPM_BYTE_ZERO,
        lo_oe_n: LPM_OE8_FLOAT,
        hi_o:    LPM_BYTE_ZERO,
        hi_oe_n: LPM_OE8_FLOAT,
        db_o:    LPM_BYTE_ZERO,
        db_oe_n: LPM_OE8_FLOAT,
        rw_o:    LPM_RW_READ,
        as_o:    1'b0
    };

endpackage

// ==== logic/lpm_ctrl.sv ====
// Low-power mode controller: sleep, standby and reset sequencing plus pin override.
// Assumes the CPU core flags the sleep instruction and its interrupt acceptance on clk,
// and that the power-down and chip init pins arrive asynchronously.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////////////////////////
module lpm_ctrl (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               power_down_pin,
    input  wire logic               chip_init_pin,
    input  wire logic               mux_mode,
    input  wire logic               sleep_instruction,
    input  wire logic               irq_request,
    input  wire logic               irq_masked,
    input  wire logic               timer_event,
    input  wire logic               timer_irq_en,
    input  wire logic               e_clk,
    input  wire lpm_pkg::lpm_pins_t core_pins,
    input  wire logic               ctl_wr,
    input  wire logic [15:0]        ctl_addr,
    input  wire logic [7:0]         ctl_wdata,
    input  wire logic               power_down_pin_flag_set,
    output logic                    cpu_clk_en,
    output logic                    periph_clk_en,
    output logic                    cpu_reset,
    output logic                    wake_vector,
    output logic                    wake_resume,
    output logic                    ram_enable,
    output logic                    ram_hold,
    output logic                    power_down_pin_flag,
    output logic                    osc_output_pin,
    output logic                    osc_output_oe_n,
    output lpm_pkg::lpm_mode_t      mode,
    output lpm_pkg::lpm_pins_t      pins
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: the first stage is read by the second only

    logic pd_s1_r;
    logic pd_s2_r;
    logic ci_s1_r;
    logic ci_s2_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            pd_s1_r <= 1'b1;
            pd_s2_r <= 1'b1;
            ci_s1_r <= 1'b1;
            ci_s2_r <= 1'b1;
        end else begin
            pd_s1_r <= power_down_pin;
            pd_s2_r <= pd_s1_r;
            ci_s1_r <= chip_init_pin;
            ci_s2_r <= ci_s1_r;
        end
    end

    wire pd_low = ~pd_s2_r;
    wire ci_low = ~ci_s2_r;

    // A timer event counts as a request only when timer_irq_en passes it on; irq_request always counts
    wire timer_req = timer_event & timer_irq_en;
    wire any_req   = irq_request | timer_req;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Mode state machine

    lpm_pkg::lpm_mode_t mode_r;
    lpm_pkg::lpm_mode_t mode_nxt;

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            lpm_pkg::LPM_ACTIVE: begin
                if (pd_low)
                    mode_nxt = lpm_pkg::LPM_POWER_DOWN_PIN;
                else if (ci_low)
                    mode_nxt = lpm_pkg::LPM_RESET;
                else if (sleep_instruction)
                    mode_nxt = lpm_pkg::LPM_SLEEP;
            end
            lpm_pkg::LPM_SLEEP: begin
                if (pd_low)
                    mode_nxt = lpm_pkg::LPM_POWER_DOWN_PIN;
                else if (ci_low)
                    mode_nxt = lpm_pkg::LPM_RESET;
                else if (any_req)
                    mode_nxt = lpm_pkg::LPM_ACTIVE;
            end
            lpm_pkg::LPM_POWER_DOWN_PIN: begin
                // Nothing but a reset start leaves standby
                if (!pd_low)
                    mode_nxt = lpm_pkg::LPM_RESET;
            end
            lpm_pkg::LPM_RESET: begin
                if (pd_low)
                    mode_nxt = lpm_pkg::LPM_POWER_DOWN_PIN;
                else if (!ci_low)
                    mode_nxt = lpm_pkg::LPM_ACTIVE;
            end
            default: mode_nxt = lpm_pkg::LPM_RESET;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset)
            mode_r <= lpm_pkg::LPM_RESET;
        else
            mode_r <= mode_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Clock enables, CPU reset and wake pulses

    wire wake = (mode_r == lpm_pkg::LPM_SLEEP) && !pd_low && !ci_low && any_req;

    always_ff @(posedge clk) begin
        if (reset) begin
            cpu_clk_en    <= 1'b0;
            periph_clk_en <= 1'b0;
            cpu_reset     <= 1'b1;
        end else begin
            cpu_clk_en    <= (mode_nxt == lpm_pkg::LPM_ACTIVE);
            periph_clk_en <= (mode_nxt == lpm_pkg::LPM_ACTIVE)
                          || (mode_nxt == lpm_pkg::LPM_SLEEP)
                          || (mode_nxt == lpm_pkg::LPM_RESET);
            cpu_reset     <= (mode_nxt == lpm_pkg::LPM_POWER_DOWN_PIN)
                          || (mode_nxt == lpm_pkg::LPM_RESET);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wake_vector <= 1'b0;
            wake_resume <= 1'b0;
        end else begin
            wake_vector <= wake && !irq_masked;
            wake_resume <= wake && irq_masked;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // RAM enable bit and standby flag; both outlast the chip reset while power holds

    always_ff @(posedge clk) begin
        if (reset)
            ram_enable <= lpm_pkg::LPM_RAM_ACCESS_ENABLE_BIT_RESET;
        else if (ctl_wr && ctl_addr == lpm_pkg::LPM_RAMCTL_ADDR
                 && mode_r == lpm_pkg::LPM_ACTIVE)
            ram_enable <= ctl_wdata[lpm_pkg::LPM_RAM_ACCESS_ENABLE_BIT_BIT];
    end

    always_ff @(posedge clk) begin
        if (reset)
            ram_hold <= 1'b0;
        else
            ram_hold <= !ram_enable || (mode_nxt == lpm_pkg::LPM_POWER_DOWN_PIN);
    end

    // Set by software only; the chip init pin does not touch it
    always_ff @(posedge clk) begin
        if (reset)
            power_down_pin_flag <= lpm_pkg::LPM_STBYFLG_RESET;
        else if (power_down_pin_flag_set && mode_r == lpm_pkg::LPM_ACTIVE)
            power_down_pin_flag <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Pin override

    logic [4:0] p2_hold_r;
    logic [7:0] lo_hold_r;
    logic [4:0] p2_oe_hold_r;
    logic [7:0] lo_oe_hold_r;

    // Capture levels while active so sleep shows the last pre-sleep state
    always_ff @(posedge clk) begin
        if (reset) begin
            p2_hold_r    <= lpm_pkg::LPM_P2_ZERO;
            lo_hold_r    <= lpm_pkg::LPM_BYTE_ZERO;
            p2_oe_hold_r <= lpm_pkg::LPM_OE5_FLOAT;
            lo_oe_hold_r <= lpm_pkg::LPM_OE8_FLOAT;
        end else if (mode_r == lpm_pkg::LPM_ACTIVE) begin
            p2_hold_r    <= core_pins.p2_o;
            lo_hold_r    <= core_pins.lo_o;
            p2_oe_hold_r <= core_pins.p2_oe_n;
            lo_oe_hold_r <= core_pins.lo_oe_n;
        end
    end

    lpm_pkg::lpm_pins_t pins_nxt;
    logic               osc_nxt;
    logic               osc_oe_nxt;

    always_comb begin
        pins_nxt   = core_pins;
        osc_nxt    = 1'b0;
        osc_oe_nxt = 1'b1;
        case (mode_nxt)
            lpm_pkg::LPM_ACTIVE: begin
                pins_nxt = core_pins;
            end
            lpm_pkg::LPM_SLEEP: begin
                pins_nxt.p2_o    = p2_hold_r;
                pins_nxt.p2_oe_n = p2_oe_hold_r;
                pins_nxt.hi_o    = lpm_pkg::LPM_BYTE_ONES;
                pins_nxt.hi_oe_n = lpm_pkg::LPM_OE8_DRIVE;
                if (mux_mode) begin
                    pins_nxt.lo_o    = lo_hold_r;
                    pins_nxt.lo_oe_n = lo_oe_hold_r;
                    pins_nxt.db_o    = lpm_pkg::LPM_BYTE_ONES;
                    pins_nxt.db_oe_n = e_clk ? lpm_pkg::LPM_OE8_FLOAT : lpm_pkg::LPM_OE8_DRIVE;
                    pins_nxt.as_o    = core_pins.as_o;
                end else begin
                    pins_nxt.lo_o    = lpm_pkg::LPM_BYTE_ONES;
                    pins_nxt.lo_oe_n = lpm_pkg::LPM_OE8_DRIVE;
                    pins_nxt.db_oe_n = lpm_pkg::LPM_OE8_FLOAT;
                    pins_nxt.rw_o    = lpm_pkg::LPM_RW_READ;
                end
            end
            lpm_pkg::LPM_RESET: begin
                pins_nxt.p2_oe_n = lpm_pkg::LPM_OE5_FLOAT;
                pins_nxt.lo_oe_n = lpm_pkg::LPM_OE8_FLOAT;
                pins_nxt.hi_oe_n = lpm_pkg::LPM_OE8_FLOAT;
                pins_nxt.rw_o    = lpm_pkg::LPM_RW_READ;
                pins_nxt.as_o    = ~e_clk;
                pins_nxt.db_o    = lpm_pkg::LPM_BYTE_ONES;
                if (mux_mode && !e_clk)
                    pins_nxt.db_oe_n = lpm_pkg::LPM_OE8_DRIVE;
                else
                    pins_nxt.db_oe_n = lpm_pkg::LPM_OE8_FLOAT;
            end
            lpm_pkg::LPM_POWER_DOWN_PIN: begin
                pins_nxt.p2_oe_n = lpm_pkg::LPM_OE5_FLOAT;
                pins_nxt.lo_oe_n = lpm_pkg::LPM_OE8_FLOAT;
                pins_nxt.hi_oe_n = lpm_pkg::LPM_OE8_FLOAT;
                pins_nxt.db_oe_n = lpm_pkg::LPM_OE8_FLOAT;
                osc_nxt          = 1'b1;
                osc_oe_nxt       = 1'b0;
            end
            default: pins_nxt = core_pins;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pins            <= lpm_pkg::LPM_PINS_RESET;
            osc_output_pin  <= 1'b0;
            osc_output_oe_n <= 1'b1;
            mode            <= lpm_pkg::LPM_RESET;
        end else begin
            pins            <= pins_nxt;
            osc_output_pin  <= osc_nxt;
            osc_output_oe_n <= osc_oe_nxt;
            mode            <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_sleep_halts_cpu: assert property (@(posedge clk) disable iff (reset)
        mode == lpm_pkg::LPM_SLEEP |-> !cpu_clk_en)
        else $error("CPU clock runs in sleep");

    a_sleep_periph_run: assert property (@(posedge clk) disable iff (reset)
        mode == lpm_pkg::LPM_SLEEP |-> periph_clk_en)
        else $error("Peripheral clock stopped in sleep");

    a_sleep_stays: assert property (@(posedge clk) disable iff (reset)
        (mode_r == lpm_pkg::LPM_SLEEP && !any_req && !pd_low && !ci_low)
        |=> mode_r == lpm_pkg::LPM_SLEEP)
        else $error("Sleep left without cause");

    a_wake_vector: assert property (@(posedge clk) disable iff (reset)
        (wake && !irq_masked) |=> wake_vector && cpu_clk_en)
        else $error("Unmasked wake did not vector");

    a_wake_resume: assert property (@(posedge clk) disable iff (reset)
        (wake && irq_masked) |=> wake_resume && !wake_vector)
        else $error("Masked wake did not resume");

    a_timer_nowake: assert property (@(posedge clk) disable iff (reset)
        (mode_r == lpm_pkg::LPM_SLEEP && !irq_request && !timer_irq_en && !pd_low && !ci_low)
        |=> mode_r == lpm_pkg::LPM_SLEEP)
        else $error("Disabled timer woke the CPU");

    sequence s_pd_low;
        !pd_s2_r;
    endsequence

    a_power_down_pin_entry: assert property (@(posedge clk) disable iff (reset)
        s_pd_low |=> cpu_reset && !periph_clk_en && mode == lpm_pkg::LPM_POWER_DOWN_PIN)
        else $error("Power-down did not enter standby");

    a_power_down_pin_exit: assert property (@(posedge clk) disable iff (reset)
        (mode_r == lpm_pkg::LPM_POWER_DOWN_PIN) |=> mode_r inside {lpm_pkg::LPM_POWER_DOWN_PIN, lpm_pkg::LPM_RESET})
        else $error("Standby left other than by reset");

    a_flag_kept: assert property (@(posedge clk) disable iff (reset)
        power_down_pin_flag |=> power_down_pin_flag)
        else $error("Standby flag lost");

    a_power_down_pin_pins: assert property (@(posedge clk) disable iff (reset)
        mode == lpm_pkg::LPM_POWER_DOWN_PIN |-> osc_output_pin && !osc_output_oe_n
        && pins.db_oe_n == lpm_pkg::LPM_OE8_FLOAT)
        else $error("Standby pin state wrong");

    a_sleep_rw: assert property (@(posedge clk) disable iff (reset)
        (mode == lpm_pkg::LPM_SLEEP && !mux_mode) |-> pins.rw_o
        && pins.hi_o == lpm_pkg::LPM_BYTE_ONES)
        else $error("Sleep address/read-write not high");

    a_reset_rw: assert property (@(posedge clk) disable iff (reset)
        mode == lpm_pkg::LPM_RESET |-> pins.rw_o && pins.hi_oe_n == lpm_pkg::LPM_OE8_FLOAT)
        else $error("Reset pin state wrong");

endmodule

// ==== dv/lpm_bus_peer.sv ====
// Far-side model: external memory and peripherals sharing the data bus.
// Assumes the pin struct from the controller; no pull resistors on the bus.
`timescale 1ns/10ps
module lpm_bus_peer (
    input  wire logic               clk,
    input  wire lpm_pkg::lpm_pins_t pins,
    output logic [7:0]              db_wire
);
    logic [7:0] last_r;

    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!pins.db_oe_n[i]) begin
                last_r[i] <= pins.db_o[i];
            end
        end
    end

    // Released bits show the inverse of the last level so a float never passes for a hold
    assign db_wire = (pins.db_o & ~pins.db_oe_n) | (~last_r & pins.db_oe_n);
endmodule

// ==== dv/test_low_power_mode_control.sv ====
// Testbench for the low-power mode controller: sleep, wake, standby and reset pins.
// Assumes one 200 MHz clock; inputs change by non-blocking assignment at posedge.
`timescale 1ns/10ps
module test_low_power_mode_control;
    logic               clk, reset, power_down_pin, chip_init_pin, mux_mode;
    logic               sleep_instruction, irq_request, irq_masked, timer_event;
    logic               timer_irq_en, e_clk, ctl_wr, power_down_pin_flag_set;
    logic [15:0]        ctl_addr;
    logic [7:0]         ctl_wdata, db_wire;
    lpm_pkg::lpm_pins_t core_pins, pins;
    lpm_pkg::lpm_mode_t mode;
    logic               cpu_clk_en, periph_clk_en, cpu_reset, wake_vector, wake_resume;
    logic               ram_enable, ram_hold, power_down_pin_flag, osc_output_pin, osc_output_oe_n;
    int                 err_count = 0;
    int                 n_checks = 0;
    localparam lpm_pkg::lpm_pins_t CORE0 = '{5'h15, 5'h00, 8'h5a, 8'h00, 8'h3c, 8'h00,
                                             8'h96, 8'h00, 1'b0, 1'b1};

    lpm_ctrl dut_u (.clk(clk), .reset(reset), .power_down_pin(power_down_pin),
        .chip_init_pin(chip_init_pin), .mux_mode(mux_mode),
        .sleep_instruction(sleep_instruction), .irq_request(irq_request),
        .irq_masked(irq_masked), .timer_event(timer_event), .timer_irq_en(timer_irq_en),
        .e_clk(e_clk), .core_pins(core_pins), .ctl_wr(ctl_wr), .ctl_addr(ctl_addr),
        .ctl_wdata(ctl_wdata), .power_down_pin_flag_set(power_down_pin_flag_set), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .cpu_reset(cpu_reset), .wake_vector(wake_vector),
        .wake_resume(wake_resume), .ram_enable(ram_enable), .ram_hold(ram_hold),
        .power_down_pin_flag(power_down_pin_flag), .osc_output_pin(osc_output_pin),
        .osc_output_oe_n(osc_output_oe_n), .mode(mode), .pins(pins));
    lpm_bus_peer peer_u (.clk(clk), .pins(pins), .db_wire(db_wire));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Pin changes pass two sync flops, so allow a few edges
    task automatic wait_mode(input lpm_pkg::lpm_mode_t m);
        for (int i = 0; i < 8 && mode !== m; i++) @(negedge clk);
        chk(mode, m);
    endtask

    task automatic go_sleep();
        @(posedge clk) sleep_instruction <= 1'b1;
        @(posedge clk) sleep_instruction <= 1'b0;
        @(negedge clk);
        chk(mode, lpm_pkg::LPM_SLEEP);
        chk({cpu_clk_en, periph_clk_en}, 2'b01);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_sleep_plain(input logic m);
        @(posedge clk) mux_mode <= 1'b0;
        go_sleep();
        @(posedge clk) core_pins.p2_o <= 5'h0a;
        @(negedge clk);
        chk(pins.p2_o, 5'h15);
        chk({pins.lo_o, pins.hi_o, pins.lo_oe_n, pins.hi_oe_n}, 32'hffff0000);
        chk({pins.rw_o, pins.db_oe_n}, 9'h1ff);
        @(posedge clk) {timer_event, timer_irq_en} <= 2'b10;
        repeat (6) @(negedge clk);
        chk(mode, lpm_pkg::LPM_SLEEP);
        // Unmasked pass wakes by a plain request, masked pass by an enabled timer event
        @(posedge clk) {irq_request, irq_masked, timer_event, timer_irq_en} <= {~m, m, m, m};
        @(posedge clk) {irq_request, timer_event, timer_irq_en} <= 3'b000;
        @(negedge clk);
        chk({mode, cpu_clk_en}, {lpm_pkg::LPM_ACTIVE, 1'b1});
        chk({wake_vector, wake_resume}, {~m, m});
        @(negedge clk);
        chk({wake_vector, wake_resume}, 2'b00);
        @(posedge clk) core_pins <= CORE0;
    endtask

    task automatic t_sleep_mux();
        @(posedge clk) {mux_mode, e_clk} <= 2'b10;
        go_sleep();
        @(posedge clk) {core_pins.lo_o, core_pins.as_o} <= {8'h11, 1'b0};
        repeat (2) @(negedge clk);
        chk({pins.lo_o, pins.as_o}, 9'h0b4);
        chk({pins.db_o, pins.db_oe_n}, 16'hff00);
        @(posedge clk) {e_clk, core_pins.as_o} <= 2'b11;
        repeat (2) @(negedge clk);
        chk({pins.db_oe_n, pins.as_o}, 9'h1ff);
        @(posedge clk) chip_init_pin <= 1'b0;
        wait_mode(lpm_pkg::LPM_RESET);
        chk({pins.rw_o, pins.p2_oe_n, pins.hi_oe_n, pins.db_oe_n}, 22'h3fffff);
        @(posedge clk) e_clk <= 1'b0;
        repeat (2) @(negedge clk);
        chk({pins.db_o, pins.db_oe_n, pins.as_o}, 17'h1fe01);
        @(posedge clk) {chip_init_pin, mux_mode, core_pins} <= {2'b10, CORE0};
        wait_mode(lpm_pkg::LPM_ACTIVE);
        chk(pins, CORE0);
    endtask

    task automatic t_standby();
        @(posedge clk) {ctl_wr, ctl_addr, ctl_wdata} <= {1'b1, 16'h0014, 8'hbf};
        @(posedge clk) {ctl_wr, power_down_pin_flag_set} <= 2'b01;
        @(posedge clk) power_down_pin_flag_set <= 1'b0;
        @(negedge clk);
        chk({ram_enable, power_down_pin_flag}, 2'b01);
        go_sleep();
        @(posedge clk) power_down_pin <= 1'b0;
        wait_mode(lpm_pkg::LPM_POWER_DOWN_PIN);
        chk({cpu_reset, cpu_clk_en, periph_clk_en, ram_hold}, 4'b1001);
        chk({osc_output_pin, osc_output_oe_n}, 2'b10);
        chk({pins.p2_oe_n, pins.lo_oe_n, pins.hi_oe_n, pins.db_oe_n}, 29'h1fffffff);
        chk(db_wire, 8'h69);
        @(posedge clk) {irq_request, sleep_instruction} <= 2'b11;
        @(posedge clk) sleep_instruction <= 1'b0;
        repeat (5) @(negedge clk);
        chk(mode, lpm_pkg::LPM_POWER_DOWN_PIN);
        @(posedge clk) {irq_request, power_down_pin} <= 2'b01;
        wait_mode(lpm_pkg::LPM_RESET);
        chk(power_down_pin_flag, 1'b1);
        wait_mode(lpm_pkg::LPM_ACTIVE);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, power_down_pin, chip_init_pin} = 3'b111;
        {mux_mode, sleep_instruction, irq_request, irq_masked} = 4'h0;
        {timer_event, timer_irq_en, e_clk, ctl_wr, power_down_pin_flag_set} = 5'h00;
        ctl_addr = 16'h0000;
        ctl_wdata = 8'h00;
        core_pins = CORE0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({mode, cpu_reset, ram_enable, power_down_pin_flag, osc_output_oe_n},
            {lpm_pkg::LPM_RESET, 4'b1101});
        @(posedge clk) reset <= 1'b0;
        wait_mode(lpm_pkg::LPM_ACTIVE);
        t_sleep_plain(1'b0);
        t_sleep_plain(1'b1);
        t_sleep_mux();
        t_standby();
        close_out();
    end

    initial begin
        #(5 * 2000);
        err_count++;
        close_out();
    end
endmodule
